/* src/uart_status_regs.vh */
// Register indices, field positions and reset values of the serial status block.
`ifndef UART_STATUS_REGS_VH
`define UART_STATUS_REGS_VH
`define IDX_SSC 10'h0BA
`define IDX_SPC 10'h098
`define IDX_SERBUF 10'h099
`define IDX_AUX 10'h0A2
`define SSC_INT_EN 0
`define SSC_OVR 1
`define SSC_BRK 2
`define SSC_FRM 3
`define SSC_DBSEL 4
`define SSC_COMBINED_IRQ_DISABLE 5
`define SSC_POS 6
`define SSC_DBUF_MODE 7
`define SPC_RXF 0
`define SPC_TXF 1
`define SPC_RB8 2
`define SPC_TB8 3
`define SPC_REN 4
`define SPC_SM2 5
`define SPC_MODE_LO 6
`define SPC_MODE_HI 7
`define AUX_BRE 6
`define SSC_RST 8'h00
`define SPC_RST 8'h00
`define AUX_RST 8'h00
`define MODE_SHIFT 2'h0
`define BREAK_BITS 11
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* src/uart_break_detect.v */
// Counter of consecutive low bit samples that flags a break condition.
`timescale 1ns/10ps
`include "uart_status_regs.vh"
module uart_break_detect #(
  parameter BREAK_BITS = `BREAK_BITS
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire bit_valid,
  input  wire bit_level,
  output reg  break_pulse
);
  reg [3:0] low_cnt_r;
  localparam integer LAST_I = BREAK_BITS - 1;
  wire [3:0] last_cnt;
  assign last_cnt = LAST_I[3:0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r   <= 4'h0;
      break_pulse <= 1'b0;
    end else begin
      break_pulse <= 1'b0;
      if (bit_valid) begin
        if (bit_level) begin
          low_cnt_r <= 4'h0;
        end else if (low_cnt_r == last_cnt) begin
          low_cnt_r   <= low_cnt_r + 4'h1;
          break_pulse <= 1'b1;
        end else if (low_cnt_r < last_cnt) begin
          low_cnt_r <= low_cnt_r + 4'h1;
        end
      end
    end
  end
endmodule

/* src/uart_tx_irq_seq.v */
// Transmit holding buffer and transmit interrupt sequencing.
`timescale 1ns/10ps
module uart_tx_irq_seq (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       dbuf_mode,
  input  wire       dbuf_sel,
  input  wire       tx_pos,
  input  wire       wr_valid,
  input  wire [8:0] wr_data,
  input  wire       stop_begin,
  input  wire       stop_end,
  input  wire       shift_busy,
  input  wire       load_ready,
  output wire       load_valid,
  output reg  [8:0] load_data,
  output reg        irq_pulse
);
  reg  buf_full_r;
  wire pos_evt;
  wire imm_irq;
  wire pos_irq;
  assign pos_evt = tx_pos ? stop_end : stop_begin;
  assign imm_irq = dbuf_mode & wr_valid & ~buf_full_r & ~shift_busy;
  assign pos_irq = pos_evt & (~dbuf_mode | buf_full_r | dbuf_sel);
  assign load_valid = buf_full_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      buf_full_r <= 1'b0;
      load_data  <= 9'h000;
      irq_pulse  <= 1'b0;
    end else begin
      irq_pulse <= imm_irq | pos_irq;
      if (wr_valid) begin
        buf_full_r <= 1'b1;
        load_data  <= wr_data;
      end else if (load_ready & buf_full_r) begin
        buf_full_r <= 1'b0;
      end
    end
  end
endmodule

/* src/uart_status_ctrl.v */
// Serial port status, error flags and interrupt control with an AXI4-Lite register slave.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "uart_status_regs.vh"
module uart_status_ctrl #(
  parameter ADDR_W = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              rx_char_done,
  input  wire [7:0]        rx_data,
  input  wire              rx_ninth,
  input  wire              rx_bit8_seen,
  input  wire              rx_frame_err,
  input  wire              rx_bit_valid,
  input  wire              rx_bit_level,
  input  wire              tx_stop_begin,
  input  wire              tx_stop_end,
  input  wire              tx_shift_busy,
  input  wire              tx_load_ready,
  output wire              tx_load_valid,
  output wire [7:0]        tx_data,
  output wire              tx_ninth,
  output reg  [1:0]        mode_select,
  output reg               rx_enable,
  output reg               multiproc_enable,
  output reg               device_reset_req,
  output reg               irq_serial,
  output reg               irq_tx
);
  // ****************************************
  // Register state
  // ****************************************
  reg        err_irq_en_r;
  reg        ovr_r;
  reg        brk_r;
  reg        frm_r;
  reg        dbsel_r;
  reg        combined_irq_disable_r;
  reg        pos_r;
  reg        dbuf_mode_r;
  reg        rxf_r;
  reg        txf_r;
  reg        rb8_r;
  reg        tb8_r;
  reg        bre_r;
  reg [7:0]  rx_buf_r;
  reg [7:0]  ssc_nxt;
  reg [7:0]  spc_nxt;
  wire [7:0] ssc_val;
  wire [7:0] spc_val;
  wire [7:0] aux_val;
  wire       break_pulse;
  wire       tx_irq_pulse;
  wire [8:0] tx_load_data;
  localparam [7:0] AUX_RST_V = `AUX_RST;

  // ****************************************
  // Bus write channel
  // ****************************************
  reg              aw_full_r;
  reg              w_full_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg [31:0]       w_data_r;
  reg [3:0]        w_strb_r;
  wire             wr_go;
  wire [9:0]       wr_idx;
  wire             wr_ssc;
  wire             wr_spc;
  wire             wr_serial_buffer;
  wire             wr_aux;
  wire             wr_hit;
  wire             wr_lane0;

  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
  assign wr_go         = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_idx        = aw_addr_r[11:2];
  assign wr_lane0      = wr_go & w_strb_r[0];
  assign wr_ssc        = wr_lane0 & (wr_idx == `IDX_SSC);
  assign wr_spc        = wr_lane0 & (wr_idx == `IDX_SPC);
  assign wr_serial_buffer       = wr_lane0 & (wr_idx == `IDX_SERBUF);
  assign wr_aux        = wr_lane0 & (wr_idx == `IDX_AUX);
  assign wr_hit        = (wr_idx == `IDX_SSC) | (wr_idx == `IDX_SPC) |
                         (wr_idx == `IDX_SERBUF) | (wr_idx == `IDX_AUX);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r    <= 1'b0;
      w_full_r     <= 1'b0;
      aw_addr_r    <= {ADDR_W{1'b0}};
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_hit) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bus read channel
  // ****************************************
  wire [9:0] rd_idx;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[11:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        if (rd_idx == `IDX_SSC) begin
          s_axi_rdata <= {24'h000000, ssc_val};
        end else if (rd_idx == `IDX_SPC) begin
          s_axi_rdata <= {24'h000000, spc_val};
        end else if (rd_idx == `IDX_SERBUF) begin
          s_axi_rdata <= {24'h000000, rx_buf_r};
        end else if (rd_idx == `IDX_AUX) begin
          s_axi_rdata <= {24'h000000, aux_val};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register views
  // ****************************************
  assign ssc_val = {dbuf_mode_r, pos_r, combined_irq_disable_r, dbsel_r, frm_r, brk_r, ovr_r, err_irq_en_r};
  assign spc_val = {mode_select, multiproc_enable, rx_enable, tb8_r, rb8_r, txf_r, rxf_r};
  assign aux_val = {1'b0, bre_r, 6'h00};

  // ****************************************
  // Status register next value
  // ****************************************
  always @* begin
    ssc_nxt = ssc_val;
    if (wr_ssc) begin
      ssc_nxt[`SSC_INT_EN] = w_data_r[`SSC_INT_EN];
      ssc_nxt[`SSC_DBSEL]  = w_data_r[`SSC_DBSEL];
      ssc_nxt[`SSC_COMBINED_IRQ_DISABLE]  = w_data_r[`SSC_COMBINED_IRQ_DISABLE];
      ssc_nxt[`SSC_POS]    = w_data_r[`SSC_POS];
      ssc_nxt[`SSC_DBUF_MODE] = w_data_r[`SSC_DBUF_MODE];
      ssc_nxt[`SSC_OVR] = ovr_r & w_data_r[`SSC_OVR];
      ssc_nxt[`SSC_BRK] = brk_r & w_data_r[`SSC_BRK];
      ssc_nxt[`SSC_FRM] = frm_r & w_data_r[`SSC_FRM];
    end
    if (rx_bit8_seen & rxf_r) begin
      ssc_nxt[`SSC_OVR] = 1'b1;
    end
    if (break_pulse) begin
      ssc_nxt[`SSC_BRK] = 1'b1;
    end
    if (rx_frame_err) begin
      ssc_nxt[`SSC_FRM] = 1'b1;
    end
  end

  // ****************************************
  // Control register next value
  // ****************************************
  always @* begin
    spc_nxt = spc_val;
    if (wr_spc) begin
      spc_nxt[`SPC_MODE_HI] = w_data_r[`SPC_MODE_HI];
      spc_nxt[`SPC_MODE_LO] = w_data_r[`SPC_MODE_LO];
      spc_nxt[`SPC_SM2] = w_data_r[`SPC_SM2];
      spc_nxt[`SPC_REN] = w_data_r[`SPC_REN];
      spc_nxt[`SPC_TB8] = w_data_r[`SPC_TB8];
      spc_nxt[`SPC_RXF] = rxf_r & w_data_r[`SPC_RXF];
      spc_nxt[`SPC_TXF] = txf_r & w_data_r[`SPC_TXF];
    end
    if (rx_char_done & ~rxf_r & (~multiproc_enable | rx_ninth)) begin
      spc_nxt[`SPC_RXF] = 1'b1;
      spc_nxt[`SPC_RB8] = rx_ninth;
    end
    if (tx_irq_pulse) begin
      spc_nxt[`SPC_TXF] = 1'b1;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      {dbuf_mode_r, pos_r, combined_irq_disable_r, dbsel_r, frm_r, brk_r, ovr_r, err_irq_en_r} <= `SSC_RST;
      {mode_select, multiproc_enable, rx_enable, tb8_r, rb8_r, txf_r, rxf_r} <= `SPC_RST;
      bre_r    <= AUX_RST_V[`AUX_BRE];
      rx_buf_r <= 8'h00;
    end else begin
      {dbuf_mode_r, pos_r, combined_irq_disable_r, dbsel_r, frm_r, brk_r, ovr_r, err_irq_en_r} <= ssc_nxt;
      {mode_select, multiproc_enable, rx_enable, tb8_r, rb8_r, txf_r, rxf_r} <= spc_nxt;
      if (wr_aux) begin
        bre_r <= w_data_r[`AUX_BRE];
      end
      if (rx_char_done & ~rxf_r & (~multiproc_enable | rx_ninth)) begin
        rx_buf_r <= rx_data;
      end
    end
  end

  // ****************************************
  // Break detection and device reset
  // ****************************************
  uart_break_detect #(
    .BREAK_BITS (`BREAK_BITS)
  ) u_break (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .bit_valid   (rx_bit_valid),
    .bit_level   (rx_bit_level),
    .break_pulse (break_pulse)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= break_pulse & bre_r;
    end
  end

  // ****************************************
  // Transmit buffer and interrupt timing
  // ****************************************
  // stop start or end
  uart_tx_irq_seq u_tx_seq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .dbuf_mode  (dbuf_mode_r),
    .dbuf_sel   (dbsel_r),
    .tx_pos     (pos_r),
    .wr_valid   (wr_serial_buffer),
    .wr_data    ({tb8_r, w_data_r[7:0]}),
    .stop_begin (tx_stop_begin),
    .stop_end   (tx_stop_end),
    .shift_busy (tx_shift_busy),
    .load_ready (tx_load_ready),
    .load_valid (tx_load_valid),
    .load_data  (tx_load_data),
    .irq_pulse  (tx_irq_pulse)
  );
  assign tx_data  = tx_load_data[7:0];
  assign tx_ninth = tx_load_data[8];

  // ****************************************
  // Interrupt routing
  // ****************************************
  wire err_req;
  assign err_req = err_irq_en_r & (ssc_nxt[`SSC_OVR] | ssc_nxt[`SSC_BRK] | ssc_nxt[`SSC_FRM]);
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_serial <= 1'b0;
      irq_tx     <= 1'b0;
    end else begin
      if (combined_irq_disable_r) begin
        irq_serial <= spc_nxt[`SPC_RXF] | err_req;
        irq_tx     <= spc_nxt[`SPC_TXF];
      end else begin
        irq_serial <= spc_nxt[`SPC_RXF] | spc_nxt[`SPC_TXF] | err_req;
        irq_tx     <= 1'b0;
      end
    end
  end
endmodule

/* verif/uart_status_props.sv */
// Concurrent checks on the ports of the serial status block.
`timescale 1ns/10ps
module uart_status_props (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        rx_char_done,
  input logic        multiproc_enable,
  input logic        rx_bit_valid,
  input logic        rx_bit_level,
  input logic        device_reset_req,
  input logic        irq_serial,
  input logic        irq_tx,
  input logic [1:0]  mode_select,
  input logic        tx_load_valid,
  input logic        tx_load_ready
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence low_bit;
    rx_bit_valid && !rx_bit_level;
  endsequence
  reset_vals_a: assert property (disable iff (1'b0)
    !aresetn |=> mode_select == 2'h0 && !irq_serial && !irq_tx) else $error("outputs not cleared by reset");
  wr_resp_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rx_irq_a: assert property (rx_char_done && !multiproc_enable |=> irq_serial)
    else $error("receive interrupt missing");
  brk_rst_a: assert property (device_reset_req |-> $past(rx_bit_valid && !rx_bit_level, 2))
    else $error("device reset without break");
  sw_clear_a: assert property ($fell(irq_serial) || $fell(irq_tx) |-> s_axi_bvalid)
    else $error("interrupt dropped without write");
  load_hold_a: assert property (tx_load_valid && !tx_load_ready |=> tx_load_valid)
    else $error("buffered character lost");
endmodule
bind uart_status_ctrl uart_status_props i_uart_status_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_char_done, .multiproc_enable, .rx_bit_valid, .rx_bit_level,
  .device_reset_req, .irq_serial, .irq_tx, .mode_select, .tx_load_valid, .tx_load_ready);

/* verif/uart_line_model.sv */
// Model of the transmit shifter on the far side of the block.
`timescale 1ns/10ps
module uart_line_model #(parameter BIT_CYC = 4) (
  input  logic aclk,
  input  logic aresetn,
  input  logic tx_load_valid,
  output logic tx_load_ready,
  output logic tx_shift_busy,
  output logic tx_stop_begin,
  output logic tx_stop_end,
  output int   n_sent,
  output int   n_end
);
  // ****************
  // Shifter
  // ****************
  int cnt;
  assign tx_load_ready = aresetn && cnt == 0;
  assign tx_shift_busy = cnt != 0;
  assign tx_stop_begin = cnt == BIT_CYC;
  assign tx_stop_end = cnt == 1;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      n_sent <= 0;
      n_end <= 0;
    end else if (tx_load_valid && tx_load_ready) begin
      cnt <= 10 * BIT_CYC;
      n_sent <= n_sent + 1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) n_end <= n_end + 1;
    end
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench of the serial status block.
`timescale 1ns/10ps
`include "uart_status_regs.vh"
module tb_top;
  localparam logic [11:0] A_SSC = {`IDX_SSC, 2'b00};
  localparam logic [11:0] A_SPC = {`IDX_SPC, 2'b00};
  localparam logic [11:0] A_BUF = {`IDX_SERBUF, 2'b00};
  localparam logic [11:0] A_AUX = {`IDX_AUX, 2'b00};
  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp, mode_select;
  wire [31:0]  s_axi_rdata;
  logic [7:0]  rx_data;
  logic [2:0]  ev;
  logic        rx_ninth, rx_bit_valid, rx_bit_level;
  wire         tx_stop_begin, tx_stop_end, tx_shift_busy, tx_load_ready, tx_load_valid;
  wire         device_reset_req, irq_serial, irq_tx;
  wire         rx_char_done = ev[0];
  wire         rx_bit8_seen = ev[1];
  wire         rx_frame_err = ev[2];
  int          n_errors, comparisons, n_rst, n_sent, n_end;
  uart_status_ctrl i_uart_status_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_char_done, .rx_data, .rx_ninth, .rx_bit8_seen, .rx_frame_err, .rx_bit_valid, .rx_bit_level,
    .tx_stop_begin, .tx_stop_end, .tx_shift_busy, .tx_load_ready, .tx_load_valid, .tx_data(), .tx_ninth(),
    .mode_select, .rx_enable(), .multiproc_enable(), .device_reset_req, .irq_serial, .irq_tx);
  uart_line_model i_uart_line_model (.aclk, .aresetn, .tx_load_valid, .tx_load_ready, .tx_shift_busy,
    .tx_stop_begin, .tx_stop_end, .n_sent, .n_end);
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (device_reset_req === 1'b1) n_rst <= n_rst + 1;
  // ****************
  // Helpers
  // ****************
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e = `RESP_OKAY);
    int k;
    logic ta, tw, tb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ta === 1'b1) s_axi_awvalid <= 1'b0;
      if (tw === 1'b1) s_axi_wvalid <= 1'b0;
      if (tb === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (k == 50) begin
      n_errors++;
      close_out();
    end
    chk("bresp", e, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] x, input logic [1:0] e = `RESP_OKAY);
    int k;
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      {ta, tb, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta === 1'b1) s_axi_arvalid <= 1'b0;
      if (tb === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (k == 50) begin
      n_errors++;
      close_out();
    end
    chk($sformatf("reg %h", a), {24'h000000, x}, d);
    chk("rresp", e, r);
  endtask
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= 3'h0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic bits(input int n, input logic lvl);
    repeat (n) begin
      rx_bit_valid <= 1'b1;
      rx_bit_level <= lvl;
      @(posedge aclk);
      rx_bit_valid <= 1'b0;
      @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask
  task automatic irqs(input logic es, input logic et);
    @(negedge aclk);
    chk("irq_serial", es, irq_serial);
    chk("irq_tx", et, irq_tx);
    @(posedge aclk);
  endtask
  task automatic wait_tx(input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(negedge aclk);
      if (irq_tx === 1'b1) break;
    end
    @(posedge aclk);
    if (k == lim) begin
      chk("irq_tx wait", 1, 0);
      close_out();
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rdc(A_SSC, 8'h00);
    rdc(A_SPC, 8'h00);
    chk("mode", 2'h0, mode_select);
    rdc(12'h000, 8'h00, `RESP_SLVERR);
    wr(12'h004, 8'hFF, `RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_errors;
    pulse(3'h4);
    irqs(0, 0);
    rdc(A_SSC, 8'h08);
    wr(A_SSC, 8'h0F);
    irqs(1, 0);
    rdc(A_SSC, 8'h09);
    wr(A_SSC, 8'h01);
    rdc(A_SSC, 8'h01);
    pulse(3'h2);
    rdc(A_SSC, 8'h01);
    rx_data <= 8'hA5;
    pulse(3'h1);
    irqs(1, 0);
    rdc(A_BUF, 8'hA5);
    pulse(3'h2);
    rdc(A_SSC, 8'h03);
    wr(A_SPC, 8'h00);
    irqs(1, 0);
    wr(A_SSC, 8'h00);
    irqs(0, 0);
    $display("test errors done");
  endtask
  task automatic t_break;
    wr(A_AUX, 8'h40);
    bits(10, 1'b0);
    bits(1, 1'b1);
    bits(10, 1'b0);
    rdc(A_SSC, 8'h00);
    chk("resets", 0, n_rst);
    bits(1, 1'b0);
    rdc(A_SSC, 8'h04);
    chk("resets", 1, n_rst);
    irqs(0, 0);
    wr(A_SSC, 8'h00);
    wr(A_AUX, 8'h00);
    $display("test break done");
  endtask
  task automatic t_single;
    int e0;
    wr(A_SPC, 8'h40);
    for (int p = 0; p < 2; p++) begin
      wr(A_SSC, p ? 8'h60 : 8'h20);
      e0 = n_end;
      wr(A_BUF, 8'h5A);
      wait_tx(200);
      chk("stop ends", e0 + p, n_end);
      irqs(0, 1);
      wr(A_SPC, 8'h40);
      repeat (60) @(posedge aclk);
      irqs(0, 0);
    end
    $display("test single done");
  endtask
  task automatic t_double;
    int s0;
    s0 = n_sent;
    wr(A_SSC, 8'hB0);
    wr(A_BUF, 8'h11);
    wait_tx(8);
    wr(A_SPC, 8'h40);
    wr(A_BUF, 8'h22);
    wait_tx(100);
    chk("sent", s0 + 1, n_sent);
    wr(A_SPC, 8'h40);
    wait_tx(100);
    chk("sent", s0 + 2, n_sent);
    wr(A_SPC, 8'h40);
    repeat (60) @(posedge aclk);
    irqs(0, 0);
    $display("test double done");
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_data, ev} = 67'h0;
    {rx_ninth, rx_bit_valid, rx_bit_level} = 3'h1;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_errors;
    t_break;
    t_single;
    t_double;
    close_out;
  end
endmodule
